// *** eod_pkg.sv ***
// shared constants and types of the electrode-off detection control block
`default_nettype none
package eod_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_GLOBAL_B  = 4'h0; // global_setup_b
  localparam logic [3:0] ADDR_DET_CFG   = 4'h1; // electrode_detect_config
  localparam logic [3:0] ADDR_SENSE_SEL = 4'h2; // lead_sense_select
  localparam logic [3:0] ADDR_STATUS    = 4'h3; // electrode_status, read only
  localparam logic [3:0] ADDR_CH1_MUX   = 4'h4; // channel 1 input selector
  localparam logic [3:0] ADDR_CH2_MUX   = 4'h5; // channel 2 input selector
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h6; // event flags, write 1 clear
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h7; // event enables

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int GB_COMP_PD  = 0; // comparator_powerdown
  localparam int GB_EXC_EN   = 1; // excitation sources on
  localparam int GB_AC_MODE  = 2; // ac excitation when set
  localparam int DC_CUR_LSB  = 0; // excitation_current_select [1:0]
  localparam int DC_CUR_SRC  = 4; // 1 current source/sink, 0 resistors
  localparam int DC_TH_LSB   = 5; // comparator_threshold [7:5]
  localparam int SS_SWAP1    = 4; // swap_polarity_ch1
  localparam int SS_SWAP2    = 5; // swap_polarity_ch2
  localparam int IRQ_CHANGE  = 0; // captured status changed
  localparam int IRQ_FRAME   = 1; // frame assembled

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_GLOBAL_B = 8'h01; // comparators powered down
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [3:0]  MUX_RDI_P    = 4'h6; // reference drive to P side
  localparam logic [3:0]  MUX_RDI_N    = 4'h7; // reference drive to N side
  localparam logic [23:0] CODE_FULL_POS = 24'h7fffff;
  localparam int NUM_CH    = 2;
  localparam int NUM_IN    = 4;   // ch1p, ch1n, ch2p, ch2n
  localparam int NUM_COMP  = 5;   // four inputs plus reference drive
  localparam int AC_DIV    = 4;   // ac excitation at data rate / 4

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic pull_up;   // resistor to supply
    logic pull_down; // resistor to ground
    logic cur_src;   // current source on
    logic cur_sink;  // current sink on
    logic comp_en;   // comparator on
  } eod_drive_s;

  typedef struct packed {
    logic [7:0]  status;  // electrode_status snapshot
    logic [7:0]  setup;   // global_setup_b snapshot
    logic [23:0] ch2;     // channel 2 code
    logic [23:0] ch1;     // channel 1 code
  } eod_frame_s;

  typedef struct packed {
    logic [7:0] global_b;
    logic [7:0] det_cfg;
    logic [7:0] sense_sel;
    logic [7:0] status;
    logic [3:0] ch1_mux;
    logic [3:0] ch2_mux;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } eod_regs_s;

endpackage
`default_nettype wire

// *** eod_sync.sv ***
// two-stage synchroniser for comparator levels from the analog side
`default_nettype none
`timescale 1ns/1ps
module eod_sync #(
  parameter int W = 5 // number of levels
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  import eod_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2; // second stage
  } eod_sync_s;

  eod_sync_s st_q;
  eod_sync_s st_d;

  // shift the levels one stage per clock
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule
`default_nettype wire

// *** eod_ac_phase.sv ***
// ac excitation phase: flips so one full period spans four conversions
`default_nettype none
`timescale 1ns/1ps
module eod_ac_phase #(
  parameter int DIV = 4 // conversions per excitation period
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic run,       // ac mode with excitation on
  input  wire logic conv_tick, // one pulse per conversion
  output var  logic phase      // 0 source on p side, 1 swapped
);
  import eod_pkg::*;

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt; // conversions within the half period
    logic          ph;  // current phase
  } eod_acp_s;

  eod_acp_s st_q;
  eod_acp_s st_d;

  // count conversions, flip phase every half period
  always_comb begin
    st_d = st_q;
    if (!run) begin
      st_d = '0;
    end else if (conv_tick) begin
      if (st_q.cnt == HALF) begin
        st_d.cnt = '0;
        st_d.ph  = ~st_q.ph;
      end else begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign phase = st_q.ph;
endmodule
`default_nettype wire

// *** eod_ctrl.sv ***
// electrode-off detection control: registers, excitation, capture, frames
//
// Behaviour
// RULE1: selector 0110/0111 routes reference drive to P/N
// RULE2: per-input sense enables from lead_sense_select
// RULE3: excitation can be off, comparators still on
// RULE4: dc excitation by resistors or current pair
// RULE5: swap bit exchanges source and sink inputs
// RULE6: two-bit field sets excitation current magnitude
// RULE7: three-bit threshold drives 4-bit comparator DAC
// RULE8: comparator results stored per input in status
// RULE9: every frame carries status and setup bytes
// RULE10: powerdown bit turns off the comparators
// RULE11: ac excitation alternates at data rate / 4
// RULE12: electrode off under resistors saturates code
// RULE13: host avoids power-up reference check in operation
// RULE14: reference comparator shares negative threshold field
// RULE15: comparators sampled once per conversion, frame-aligned
// RULE16: ac drive only on enabled inputs, excitation on
//
// Our own choices: the register addresses and the plain strobed port.
`default_nettype none
`timescale 1ns/1ps
module eod_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // register port
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [7:0]                    reg_rdata,
  // converter side, same clock
  input  wire logic                          conv_done,
  input  wire logic [23:0]                   ch1_code,
  input  wire logic [23:0]                   ch2_code,
  // analog comparators, asynchronous
  input  wire logic [eod_pkg::NUM_COMP-1:0]  comp_raw,
  // analog controls
  output var  eod_pkg::eod_drive_s [eod_pkg::NUM_IN-1:0] in_drive,
  output var  logic                          rdrv_comp_en,
  output var  logic [1:0]                    exc_current,
  output var  logic [3:0]                    dac_level_p,
  output var  logic [3:0]                    dac_level_n,
  output var  logic [eod_pkg::NUM_CH-1:0]    rdi_to_p,
  output var  logic [eod_pkg::NUM_CH-1:0]    rdi_to_n,
  // output frame
  output var  logic                          frame_valid,
  output var  eod_pkg::eod_frame_s           frame,
  // interrupt
  output var  logic                          irq
);
  import eod_pkg::*;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // comparator level for the high trip point
  function automatic logic [3:0] dac_high(input logic [2:0] th);
    dac_high = {1'b1, th};
  endfunction

  // comparator level for the low trip point, mirrored around mid scale
  function automatic logic [3:0] dac_low(input logic [2:0] th);
    dac_low = {1'b0, ~th};
  endfunction

  // register read decode
  function automatic logic [7:0] read_mux(input eod_regs_s r,
                                          input logic [3:0] a);
    unique case (a)
      ADDR_GLOBAL_B:  read_mux = r.global_b;
      ADDR_DET_CFG:   read_mux = r.det_cfg;
      ADDR_SENSE_SEL: read_mux = r.sense_sel;
      ADDR_STATUS:    read_mux = r.status;
      ADDR_CH1_MUX:   read_mux = {4'h0, r.ch1_mux};
      ADDR_CH2_MUX:   read_mux = {4'h0, r.ch2_mux};
      ADDR_IRQ_STAT:  read_mux = {6'h00, r.irq_stat};
      ADDR_IRQ_MASK:  read_mux = {6'h00, r.irq_mask};
      default:        read_mux = 8'h00; // unmapped reads as zero
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    eod_regs_s                  regs;        // software registers
    logic [7:0]                 rdata;       // read answer
    eod_drive_s [NUM_IN-1:0]    drive;       // per-input excitation
    logic                       rdrv_en;     // reference comparator on
    logic [1:0]                 cur;         // current magnitude
    logic [3:0]                 dac_p;       // positive-side level
    logic [3:0]                 dac_n;       // negative-side level
    logic [NUM_CH-1:0]          rdi_p;       // reference to p inputs
    logic [NUM_CH-1:0]          rdi_n;       // reference to n inputs
    logic                       fvalid;      // frame strobe
    eod_frame_s                 frame;       // assembled frame
    logic                       irq;         // interrupt level
  } eod_state_s;

  eod_state_s st_q;
  eod_state_s st_d;

  logic [NUM_COMP-1:0] comp_sync; // comparators after synchroniser
  logic                ac_phase;  // current ac excitation phase
  logic                ac_run;    // ac excitation running

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------

  // bring comparator levels into the clock domain
  eod_sync #(
    .W (NUM_COMP)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (comp_raw),
    .sync_out (comp_sync)
  );

  // RULE11: phase divider
  assign ac_run = st_q.regs.global_b[GB_AC_MODE]
                & st_q.regs.global_b[GB_EXC_EN];

  eod_ac_phase #(
    .DIV (AC_DIV)
  ) u_acp (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .run       (ac_run),
    .conv_tick (conv_done),
    .phase     (ac_phase)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic       comp_on;    // comparators powered
    logic       exc_on;     // excitation allowed
    logic       cur_mode;   // current pair instead of resistors
    logic       ac_mode;    // ac excitation selected
    logic [1:0] swap;       // per-channel polarity swap
    logic [1:0] hi_side;    // per-channel: 0 p is high, 1 n is high
    logic [7:0] new_stat;   // status sample this conversion
    logic [1:0] ev;         // events this cycle
    logic [1:0] w1c;        // flags cleared by software
    logic [1:0] dc_off;     // channel electrode off under resistors
    logic [23:0] c1;        // channel 1 code to frame
    logic [23:0] c2;        // channel 2 code to frame
    comp_on  = 1'b0;
    exc_on   = 1'b0;
    cur_mode = 1'b0;
    ac_mode  = 1'b0;
    swap     = 2'b00;
    hi_side  = 2'b00;
    new_stat = 8'h00;
    ev       = 2'b00;
    w1c      = 2'b00;
    dc_off   = 2'b00;
    c1       = ch1_code;
    c2       = ch2_code;

    st_d        = st_q;
    st_d.rdata  = 8'h00;
    st_d.fvalid = 1'b0;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_GLOBAL_B:  st_d.regs.global_b  = reg_wdata;
        ADDR_DET_CFG:   st_d.regs.det_cfg   = reg_wdata;
        ADDR_SENSE_SEL: st_d.regs.sense_sel = reg_wdata;
        ADDR_CH1_MUX:   st_d.regs.ch1_mux   = reg_wdata[3:0];
        ADDR_CH2_MUX:   st_d.regs.ch2_mux   = reg_wdata[3:0];
        ADDR_IRQ_STAT:  w1c                 = reg_wdata[1:0];
        ADDR_IRQ_MASK:  st_d.regs.irq_mask  = reg_wdata[1:0];
        default:        ; // status and unmapped writes ignored
      endcase
    end

    // register reads, answer in the next cycle only
    if (reg_rd) begin
      st_d.rdata = read_mux(st_q.regs, reg_addr);
    end

    // decode the live configuration
    // RULE10: powerdown gate
    comp_on  = ~st_q.regs.global_b[GB_COMP_PD];
    // RULE3: excitation switch
    exc_on   = st_q.regs.global_b[GB_EXC_EN];
    // RULE4: source type
    cur_mode = st_q.regs.det_cfg[DC_CUR_SRC];
    ac_mode  = st_q.regs.global_b[GB_AC_MODE];
    swap     = {st_q.regs.sense_sel[SS_SWAP2],
                st_q.regs.sense_sel[SS_SWAP1]};

    // per-channel excitation
    for (int c = 0; c < NUM_CH; c++) begin
      // RULE5: polarity swap
      hi_side[c] = swap[c];
      // RULE11: ac alternation
      if (ac_mode) begin
        hi_side[c] = swap[c] ^ ac_phase;
      end
      for (int s = 0; s < 2; s++) begin
        // RULE2: per-input enable
        logic en;
        logic hi;
        en = st_q.regs.sense_sel[2*c+s];
        hi = (s == 0) ? ~hi_side[c] : hi_side[c];
        st_d.drive[2*c+s].comp_en = en & comp_on;
        // RULE16: drive only when enabled
        st_d.drive[2*c+s].cur_src   = en & exc_on & (cur_mode | ac_mode)
                                    & hi;
        st_d.drive[2*c+s].cur_sink  = en & exc_on & (cur_mode | ac_mode)
                                    & ~hi;
        // RULE4: resistors, p pulled up
        st_d.drive[2*c+s].pull_up   = en & exc_on & ~cur_mode & ~ac_mode
                                    & (s == 0);
        st_d.drive[2*c+s].pull_down = en & exc_on & ~cur_mode & ~ac_mode
                                    & (s == 1);
      end
    end

    // reference drive comparator follows the powerdown bit
    st_d.rdrv_en = comp_on;

    // RULE6: current magnitude
    st_d.cur = st_q.regs.det_cfg[DC_CUR_LSB +: 2];

    // RULE7: threshold to dac
    st_d.dac_p = dac_high(st_q.regs.det_cfg[DC_TH_LSB +: 3]);
    // RULE14: shared negative level
    st_d.dac_n = dac_low(st_q.regs.det_cfg[DC_TH_LSB +: 3]);

    // RULE1: reference drive routing
    st_d.rdi_p = {st_q.regs.ch2_mux == MUX_RDI_P,
                  st_q.regs.ch1_mux == MUX_RDI_P};
    st_d.rdi_n = {st_q.regs.ch2_mux == MUX_RDI_N,
                  st_q.regs.ch1_mux == MUX_RDI_N};

    // conversion boundary: capture and frame
    if (conv_done) begin
      // RULE8: one bit per monitored input
      new_stat = {3'b000, comp_sync & {NUM_COMP{comp_on}}};
      // RULE15: sampled with the frame
      st_d.regs.status = new_stat;
      ev[IRQ_FRAME]  = 1'b1;
      ev[IRQ_CHANGE] = (new_stat != st_q.regs.status);

      // RULE12: resistor saturation
      for (int c = 0; c < NUM_CH; c++) begin
        dc_off[c] = exc_on & ~cur_mode & ~ac_mode
                  & |(new_stat[2*c +: 2] & st_q.regs.sense_sel[2*c +: 2]);
      end
      if (dc_off[0]) begin
        c1 = CODE_FULL_POS;
      end
      if (dc_off[1]) begin
        c2 = CODE_FULL_POS;
      end

      // RULE9: status in every frame
      st_d.frame.status = new_stat;
      st_d.frame.setup  = st_q.regs.global_b;
      st_d.frame.ch1    = c1;
      st_d.frame.ch2    = c2;
      st_d.fvalid       = 1'b1;
    end

    // sticky event flags, a new event wins over a clear
    st_d.regs.irq_stat = (st_q.regs.irq_stat & ~w1c) | ev;
    st_d.irq = |(st_d.regs.irq_stat & st_d.regs.irq_mask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q               <= '0;
      st_q.regs.global_b <= RST_GLOBAL_B;
      st_q.regs.det_cfg  <= RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------------
  assign reg_rdata    = st_q.rdata;
  assign in_drive     = st_q.drive;
  assign rdrv_comp_en = st_q.rdrv_en;
  assign exc_current  = st_q.cur;
  assign dac_level_p  = st_q.dac_p;
  assign dac_level_n  = st_q.dac_n;
  assign rdi_to_p     = st_q.rdi_p;
  assign rdi_to_n     = st_q.rdi_n;
  assign frame_valid  = st_q.fvalid;
  assign frame        = st_q.frame;
  assign irq          = st_q.irq;
endmodule
`default_nettype wire

// *** eod_ctrl_checker.sv ***
// port-level assertions for the electrode-off detection control block
`timescale 1ns/1ps
`default_nettype none
module eod_ctrl_checker (
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic [3:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               conv_done,
  input wire logic [23:0]        ch1_code,
  input wire logic [1:0]         exc_current,
  input wire logic [3:0]         dac_level_p,
  input wire logic [3:0]         dac_level_n,
  input wire logic               frame_valid,
  input wire eod_pkg::eod_frame_s frame,
  input wire logic               irq
);
  import eod_pkg::*;
  // ---------------------------------------------------------------
  // shared clock, reset and multi-step sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // config write, then a quiet cycle
  sequence det_write;
    (reg_wr && reg_addr == ADDR_DET_CFG)
      ##1 !(reg_wr && reg_addr == ADDR_DET_CFG);
  endsequence
  // mask cleared, then a quiet cycle
  sequence mask_off;
    (reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata[1:0] == 2'h0)
      ##1 !(reg_wr && reg_addr == ADDR_IRQ_MASK);
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_exc_cur_follows: assert property (det_write |=>
    exc_current == $past(reg_wdata[1:0], 2))
    else $error("excitation current wrong");
  a_dac_from_th: assert property (det_write |=>
    dac_level_p == {1'b1, $past(reg_wdata[7:5], 2)})
    else $error("positive dac level wrong");
  a_dac_n_shared: assert property (det_write |=>
    dac_level_n == {1'b0, ~$past(reg_wdata[7:5], 2)})
    else $error("negative dac level wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_unmapped_read: assert property (reg_rd && reg_addr[3] |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_frame_follows: assert property (conv_done |=> frame_valid)
    else $error("no frame after conversion");
  a_frame_cause: assert property (frame_valid |-> $past(conv_done))
    else $error("frame without conversion");
  a_frame_hold: assert property (!frame_valid && !$past(sys_rst)
    |-> $stable(frame)) else $error("frame changed while idle");
  a_ch1_pass: assert property (frame_valid
    && frame.ch1 != CODE_FULL_POS |-> frame.ch1 == $past(ch1_code))
    else $error("channel 1 code altered");
  a_status_pad: assert property (frame_valid |->
    frame.status[7:5] == 3'h0) else $error("status pad bits set");
  a_pd_status: assert property (frame_valid
    && frame.setup[GB_COMP_PD] |-> frame.status == 8'h00)
    else $error("status set while powered down");
  a_irq_masked: assert property (mask_off |=> !irq)
    else $error("irq high while masked");
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking testbench for the electrode-off detection control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eod_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic                  sys_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [3:0]            reg_addr = 4'h0;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_rdata;
  logic                  conv_done = 1'b0;
  logic [23:0]           ch1_code = 24'h000000;
  logic [23:0]           ch2_code = 24'h000000;
  logic [NUM_COMP-1:0]   comp_raw = 5'h00;
  eod_drive_s [NUM_IN-1:0] in_drive;
  logic                  rdrv_comp_en;
  logic [1:0]            exc_current;
  logic [3:0]            dac_level_p;
  logic [3:0]            dac_level_n;
  logic [NUM_CH-1:0]     rdi_to_p;
  logic [NUM_CH-1:0]     rdi_to_n;
  logic                  frame_valid;
  eod_frame_s            frame;
  logic                  irq;
  int                    failures = 0;
  int                    n_checks = 0;
  int                    cycles = 0;
  logic [7:0]            rd_val;
  // 40 ns clock
  always #20 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // design under test
  // ---------------------------------------------------------------
  eod_ctrl DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_done, .ch1_code, .ch2_code, .comp_raw, .in_drive,
    .rdrv_comp_en, .exc_current, .dac_level_p, .dac_level_n, .rdi_to_p,
    .rdi_to_n, .frame_valid, .frame, .irq);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value and log a mismatch
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write cycle, then let derived outputs settle
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // one read cycle, data taken in the answer cycle
  task automatic rd(logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask
  // one conversion pulse; returns in the frame cycle
  task automatic conv(logic [23:0] c1, logic [23:0] c2);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    ch1_code <= c1;
    ch2_code <= c2;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    @(negedge sys_clk);
  endtask
  // hang guard, tests need well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset values, unmapped read, read-only status
    for (int i = 0; i < 8; i++) begin
      rd(4'(i));
      check("reset value", rd_val, i ? 8'h00 : RST_GLOBAL_B);
    end
    wr(ADDR_STATUS, 8'h1f);
    rd(ADDR_STATUS);
    check("status read only", rd_val, 8'h00);
    rd(4'h9);
    check("unmapped read", rd_val, 8'h00);
    // current and threshold fields
    wr(ADDR_DET_CFG, 8'hb3);
    rd(ADDR_DET_CFG);
    check("config readback", rd_val, 8'hb3);
    check("current select", exc_current, 2'h3);
    check("dac p", dac_level_p, 4'hd);
    check("dac n", dac_level_n, 4'h2);
    // reference drive routing, both selector codes on both channels
    wr(ADDR_CH1_MUX, MUX_RDI_P);
    wr(ADDR_CH2_MUX, MUX_RDI_N);
    check("route p", rdi_to_p, 2'b01);
    check("route n", rdi_to_n, 2'b10);
    wr(ADDR_CH1_MUX, MUX_RDI_N);
    wr(ADDR_CH2_MUX, MUX_RDI_P);
    check("route p swap", rdi_to_p, 2'b10);
    check("route n swap", rdi_to_n, 2'b01);
    // dc current pair, channel 1 swapped
    wr(ADDR_GLOBAL_B, 8'h02);
    wr(ADDR_DET_CFG, 8'h10);
    wr(ADDR_SENSE_SEL, 8'h1f);
    check("ch1p sink", in_drive[0], 5'b00011);
    check("ch1n source", in_drive[1], 5'b00101);
    check("ch2p source", in_drive[2], 5'b00101);
    check("ch2n sink", in_drive[3], 5'b00011);
    // dc resistors
    wr(ADDR_DET_CFG, 8'h00);
    check("p pull up", in_drive[0], 5'b10001);
    check("n pull down", in_drive[1], 5'b01001);
    // excitation off, comparators on; then comparators off
    wr(ADDR_GLOBAL_B, 8'h00);
    check("sense only", in_drive[3], 5'b00001);
    wr(ADDR_GLOBAL_B, 8'h01);
    check("comps off", in_drive[0], 5'b00000);
    check("ref comp off", rdrv_comp_en, 1'b0);
    // capture with channel 1 positive input open
    wr(ADDR_GLOBAL_B, 8'h02);
    wr(ADDR_SENSE_SEL, 8'h0f);
    wr(ADDR_IRQ_MASK, 8'h02);
    check("ref comp on", rdrv_comp_en, 1'b1);
    @(posedge sys_clk) comp_raw <= 5'h01;
    repeat (4) @(posedge sys_clk);
    conv(24'h123456, 24'h0abcde);
    check("frame valid", frame_valid, 1'b1);
    check("frame", frame, {8'h01, 8'h02, 24'h0abcde, CODE_FULL_POS});
    check("irq raised", irq, 1'b1);
    rd(ADDR_STATUS);
    check("status", rd_val, 8'h01);
    rd(ADDR_IRQ_STAT);
    check("event flags", rd_val, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h00);
    check("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h03);
    check("irq unmasked", irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h03);
    check("irq cleared", irq, 1'b0);
    rd(ADDR_IRQ_STAT);
    check("flags cleared", rd_val, 8'h00);
    // current mode does not saturate; powerdown zeroes status
    wr(ADDR_DET_CFG, 8'h10);
    conv(24'h123456, 24'h0abcde);
    check("no saturation", frame.ch1, 24'h123456);
    wr(ADDR_GLOBAL_B, 8'h03);
    repeat (3) @(posedge sys_clk);
    conv(24'h000001, 24'h000002);
    check("pd status", frame.status, 8'h00);
    check("pd setup", frame.setup, 8'h03);
    // ac excitation on channel 1 positive only
    wr(ADDR_SENSE_SEL, 8'h01);
    wr(ADDR_GLOBAL_B, 8'h06);
    check("ac phase 0", in_drive[0], 5'b00101);
    check("ac disabled in", in_drive[2], 5'b00000);
    conv(24'h0, 24'h0);
    repeat (2) @(negedge sys_clk);
    check("ac hold", in_drive[0], 5'b00101);
    conv(24'h0, 24'h0);
    repeat (2) @(negedge sys_clk);
    check("ac phase 1", in_drive[0], 5'b00011);
    repeat (2) conv(24'h0, 24'h0);
    repeat (2) @(negedge sys_clk);
    check("ac phase 0 again", in_drive[0], 5'b00101);
    wr(ADDR_GLOBAL_B, 8'h04);
    check("ac exc off", in_drive[0], 5'b00001);
    // second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_GLOBAL_B);
    check("reset again", rd_val, 8'h01);
    report_and_stop();
  end
endmodule
// checker on every control block
bind eod_ctrl eod_ctrl_checker u_chk (.sys_clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_done, .ch1_code,
  .exc_current, .dac_level_p, .dac_level_n, .frame_valid, .frame, .irq);
`default_nettype wire
